/* fault_seq_pkg.sv */
// Constants, register map and carrier types for the shared-fault sequencing block.
// Assumes a 25 MHz pclk, an APB master, and pull-ups on both open-drain lines.
// Contract
// - Output-disabling fault records log, sets present flag
// - Disabling on shared line records fault log
// - Host command stores manual telemetry snapshot
// - Alert output driven low at fault
// - Latch status when responder held off
// - Propagating channel pulls shared fault line low
// - Responder stops delivery when line low
// - Controller reports io status, manager shared status
// - Manager deasserts supply enable on response
// - Optional turn-off delay before enable drop
// - Retry delay then release if fault cleared
// - Fault line rising edge is time zero
// - Wait turn-on delay from time zero
// - Controller ramps rise time; manager asserts enable
// - Ignore setting lets channel start regardless
// - Input-off warning below turn-off threshold
// - Let timebase line toggle in normal operation
// - Input loss holds timebase line low
// - Disable output when timebase stops toggling
// - Release timebase when input above turn-on
// - Timebase restart is time zero
package fault_seq_pkg;
	localparam logic [7:0] ADDR_CTRL       = 8'h00;
	localparam logic [7:0] ADDR_ON_DELAY   = 8'h04;
	localparam logic [7:0] ADDR_ON_RISE    = 8'h08;
	localparam logic [7:0] ADDR_OFF_DELAY  = 8'h0C;
	localparam logic [7:0] ADDR_RETRY      = 8'h10;
	localparam logic [7:0] ADDR_STATUS     = 8'h14;
	localparam logic [7:0] ADDR_CMD        = 8'h18;
	localparam logic [7:0] ADDR_LOG_COUNT  = 8'h1C;
	localparam logic [7:0] ADDR_ID         = 8'h20;
	// Control bit positions
	localparam int CTRL_ON          = 0;
	localparam int CTRL_PROPAGATE   = 1;
	localparam int CTRL_RESPOND     = 2;
	localparam int CTRL_RETRY       = 3;
	localparam int CTRL_IGNORE_RESP = 4;
	localparam int CTRL_MANAGER     = 5;
	localparam int CTRL_HONOR_TOFF  = 6;
	localparam int CTRL_USE_TB      = 7;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0085;
	// Status bit positions; W1C on the sticky ones
	localparam int ST_LOG_PRESENT = 0;
	localparam int ST_IO_LOW      = 1;
	localparam int ST_SHARED_IN   = 2;
	localparam int ST_INPUT_OFF   = 3;
	localparam int ST_TB_LOW      = 4;
	localparam int ST_POWER_GOOD  = 5;
	localparam int ST_LINE_DRIVE  = 6;
	localparam int CMD_STORE = 0;
	localparam int CMD_CLEAR = 1;
	localparam logic [15:0] ON_DELAY_RESET  = 16'h0010;
	localparam logic [15:0] ON_RISE_RESET   = 16'h0010;
	localparam logic [15:0] TOFF_RESET      = 16'h0008;
	localparam logic [15:0] RETRY_RESET     = 16'h0020;
	localparam logic [31:0] DEVICE_ID       = 32'h0000_5A5A; // Arbitrary value
	// Timer tick per 10 us; timebase tick 320 ns, stalled line declared after 4 timebase ticks' silence
	localparam int TICK_NS        = 10000;
	localparam int CLK_NS         = 40;
	localparam int TICK_CYCLES    = TICK_NS / CLK_NS;
	localparam int TB_TICK_NS     = 320;
	localparam int TB_STALL_NS    = 1280;
	localparam int TB_STALL_CYC   = TB_STALL_NS / CLK_NS;
	localparam int TB_HALF_CYC    = (TB_TICK_NS / 2) / CLK_NS;

	typedef enum logic [2:0] {
		ST_OFF     = 3'b000,
		ST_WAIT_ON = 3'b001,
		ST_RAMP    = 3'b010,
		ST_ON      = 3'b011,
		ST_TOFF    = 3'b100,
		ST_FAULTED = 3'b101
	} chan_state_t;

	typedef struct packed {
		logic on;
		logic propagate;
		logic respond;
		logic retry;
		logic ignore_resp;
		logic manager;
		logic honor_toff;
		logic use_tb;
	} chan_cfg_t;

	// Open-drain pin as drive value and output enable
	typedef struct packed {
		logic o;
		logic oe;
	} od_drive_t;
endpackage

/* shared_fault_sequence_coord.sv */
// Single-channel shared-fault and sequencing coordinator with APB registers.
// Assumes the line inputs come straight from pins and need synchronising.
`timescale 1ns/1ps
module shared_fault_sequence_coord (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [7:0]                  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic                        fault_detect,
	input  wire logic                        input_below_off,
	input  wire logic                        input_above_on,
	input  wire logic                        shared_fault_line_i,
	output fault_seq_pkg::od_drive_t         shared_fault_line,
	input  wire logic                        shared_timebase_line_i,
	output fault_seq_pkg::od_drive_t         shared_timebase_line,
	output logic                             alert_out_n,
	output logic                             supply_output_enable,
	output logic                             power_enable,
	output logic      [15:0]                 ramp_level,
	output logic                             log_write,
	output logic                             log_manual
);
	import fault_seq_pkg::*;

	function automatic logic [15:0] dec16(input logic [15:0] v);
		dec16 = (v == 16'h0000) ? 16'h0000 : v - 16'h0001;
	endfunction

	// Two-flop synchronisers on pins
	logic [1:0] sync_reg, sync_next;
	logic [1:0] sync2_reg, sync2_next;
	logic [1:0] in_sync_reg, in_sync_next;
	logic [1:0] in_sync2_reg, in_sync2_next;
	logic       fault_line_d_reg, fault_line_d_next;
	always_comb begin
		sync_next = {shared_fault_line_i, shared_timebase_line_i};
		sync2_next = sync_reg;
		in_sync_next = {input_below_off, input_above_on};
		in_sync2_next = in_sync_reg;
		fault_line_d_next = sync2_reg[1];
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_reg <= 2'b11;
			sync2_reg <= 2'b11;
			in_sync_reg <= 2'b00;
			in_sync2_reg <= 2'b00;
			fault_line_d_reg <= 1'b1;
		end else begin
			sync_reg <= sync_next;
			sync2_reg <= sync2_next;
			in_sync_reg <= in_sync_next;
			in_sync2_reg <= in_sync2_next;
			fault_line_d_reg <= fault_line_d_next;
		end
	end
	logic fault_line_lvl, tb_lvl, vin_low, vin_high, fault_line_rise;
	assign fault_line_lvl  = sync2_reg[1];
	assign tb_lvl          = sync2_reg[0];
	assign vin_low         = in_sync2_reg[1];
	assign vin_high        = in_sync2_reg[0];
	assign fault_line_rise = fault_line_lvl & ~fault_line_d_reg;

	// Registers written by software
	logic [31:0] ctrl_reg, ctrl_next;
	logic [15:0] ton_reg, ton_next, rise_reg, rise_next, toff_reg, toff_next, retry_reg, retry_next;
	logic        wr, rd;
	chan_cfg_t   cfg;
	assign wr  = psel & penable & pwrite;
	assign rd  = psel & penable & ~pwrite;
	assign cfg = '{
		on:          ctrl_reg[CTRL_ON],
		propagate:   ctrl_reg[CTRL_PROPAGATE],
		respond:     ctrl_reg[CTRL_RESPOND],
		retry:       ctrl_reg[CTRL_RETRY],
		ignore_resp: ctrl_reg[CTRL_IGNORE_RESP],
		manager:     ctrl_reg[CTRL_MANAGER],
		honor_toff:  ctrl_reg[CTRL_HONOR_TOFF],
		use_tb:      ctrl_reg[CTRL_USE_TB]
	};
	always_comb begin
		ctrl_next = ctrl_reg;
		ton_next = ton_reg;
		rise_next = rise_reg;
		toff_next = toff_reg;
		retry_next = retry_reg;
		if (wr) begin
			case (paddr)
				ADDR_CTRL:       ctrl_next  = {24'h00_0000, pwdata[7:0]};
				ADDR_ON_DELAY:   ton_next   = pwdata[15:0];
				ADDR_ON_RISE:    rise_next  = pwdata[15:0];
				ADDR_OFF_DELAY:  toff_next  = pwdata[15:0];
				ADDR_RETRY:      retry_next = pwdata[15:0];
				default:         ctrl_next  = ctrl_reg;
			endcase
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= CTRL_RESET;
			ton_reg <= ON_DELAY_RESET;
			rise_reg <= ON_RISE_RESET;
			toff_reg <= TOFF_RESET;
			retry_reg <= RETRY_RESET;
		end else begin
			ctrl_reg <= ctrl_next;
			ton_reg <= ton_next;
			rise_reg <= rise_next;
			toff_reg <= toff_next;
			retry_reg <= retry_next;
		end
	end

	// Timebase: watch for stall and restart; toggle our own drive at half tick
	logic [7:0] tb_idle_reg, tb_idle_next;
	logic       tb_d_reg, tb_d_next, tb_stalled_reg, tb_stalled_next;
	logic [7:0] tb_div_reg, tb_div_next;
	logic       tb_phase_reg, tb_phase_next;
	logic       tb_restart, tb_hold_low;
	always_comb begin
		tb_d_next = tb_lvl;
		tb_idle_next = (tb_lvl != tb_d_reg) ? 8'h00 :
			(tb_idle_reg == 8'(TB_STALL_CYC)) ? tb_idle_reg : tb_idle_reg + 8'h01;
		// Once stalled, only a rising edge clears it, so reset and the hold give no false restart
		tb_stalled_next = tb_stalled_reg ? ~(tb_lvl & ~tb_d_reg) :
			((tb_idle_next == 8'(TB_STALL_CYC)) & ~tb_lvl);
		tb_div_next = (tb_div_reg == 8'(TB_HALF_CYC - 1)) ? 8'h00 : tb_div_reg + 8'h01;
		tb_phase_next = (tb_div_reg == 8'(TB_HALF_CYC - 1)) ? ~tb_phase_reg : tb_phase_reg;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tb_d_reg <= 1'b1;
			tb_idle_reg <= 8'h00;
			tb_stalled_reg <= 1'b1;
			tb_div_reg <= 8'h00;
			tb_phase_reg <= 1'b1;
		end else begin
			tb_d_reg <= tb_d_next;
			tb_idle_reg <= tb_idle_next;
			tb_stalled_reg <= tb_stalled_next;
			tb_div_reg <= tb_div_next;
			tb_phase_reg <= tb_phase_next;
		end
	end
	// Hold low from input loss until input is back above turn-on
	logic vin_hold_reg, vin_hold_next;
	always_comb begin
		vin_hold_next = vin_hold_reg;
		if (vin_low)
			vin_hold_next = 1'b1;
		else if (vin_high)
			vin_hold_next = 1'b0;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			vin_hold_reg <= 1'b1;
		else
			vin_hold_reg <= vin_hold_next;
	end
	assign tb_hold_low = vin_hold_reg;
	assign tb_restart  = tb_stalled_reg & ~tb_stalled_next;
	// Low phase or hold drives low; the high phase is released, never driven
	assign shared_timebase_line.o  = 1'b0;
	assign shared_timebase_line.oe = tb_hold_low | ~tb_phase_reg;

	// Channel state machine
	chan_state_t state_reg, state_next;
	logic [15:0] cnt_reg, cnt_next, ramp_reg, ramp_next;
	logic [15:0] tick_reg, tick_next;
	logic        tick, prop_reg, prop_next, respond_low, tb_off, fault_stop;
	logic        log_evt, log_is_resp;
	logic [1:0]  prop_hist_reg, prop_hist_next;
	assign tick        = (tick_reg == 16'(TICK_CYCLES - 1));
	// Our own pull still reads low for two cycles after release, through the synchroniser
	assign respond_low = cfg.respond & ~cfg.ignore_resp & ~fault_line_lvl & ~prop_reg & ~|prop_hist_reg;
	// The restart cycle must not count as stalled, or the restart would be swallowed
	assign tb_off      = cfg.use_tb & tb_stalled_reg & ~tb_restart;
	assign fault_stop  = fault_detect;
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		ramp_next = ramp_reg;
		prop_next = prop_reg;
		log_evt = 1'b0;
		log_is_resp = 1'b0;
		tick_next = tick ? 16'h0000 : tick_reg + 16'h0001;
		prop_hist_next = {prop_hist_reg[0], prop_reg};
		case (state_reg)
			ST_OFF, ST_WAIT_ON, ST_RAMP, ST_ON: begin
				if (fault_stop && (state_reg != ST_OFF)) begin
					state_next = ST_FAULTED;
					cnt_next = retry_reg;
					ramp_next = 16'h0000;
					prop_next = cfg.propagate;
					log_evt = 1'b1;
				end else if (respond_low || tb_off || !cfg.on) begin
					if (state_reg != ST_OFF && respond_low && cfg.manager && cfg.honor_toff) begin
						state_next = ST_TOFF;
						cnt_next = toff_reg;
					end else begin
						state_next = ST_OFF;
						ramp_next = 16'h0000;
					end
					log_evt = respond_low && (state_reg != ST_OFF);
					log_is_resp = respond_low;
				end else if (state_reg == ST_OFF && (fault_line_rise || tb_restart || cfg.ignore_resp
						|| !cfg.respond)) begin
					state_next = ST_WAIT_ON;
					cnt_next = ton_reg;
				end else if (state_reg == ST_WAIT_ON && tick) begin
					cnt_next = dec16(cnt_reg);
					if (cnt_reg == 16'h0000) begin
						state_next = cfg.manager ? ST_ON : ST_RAMP;
						cnt_next = rise_reg;
					end
				end else if (state_reg == ST_RAMP && tick) begin
					cnt_next = dec16(cnt_reg);
					ramp_next = (rise_reg == 16'h0000) ? 16'hFFFF : 16'(32'(ramp_reg) + 32'hFFFF / 32'(rise_reg));
					if (cnt_reg == 16'h0000) begin
						state_next = ST_ON;
						ramp_next = 16'hFFFF;
					end
				end
			end
			ST_TOFF: begin
				if (tick)
					cnt_next = dec16(cnt_reg);
				if (cnt_reg == 16'h0000)
					state_next = ST_OFF;
			end
			ST_FAULTED: begin
				if (cfg.retry && tick)
					cnt_next = dec16(cnt_reg);
				if (cfg.retry && cnt_reg == 16'h0000 && !fault_stop) begin
					prop_next = 1'b0;
					state_next = ST_OFF;
				end
			end
			default: state_next = ST_OFF;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_OFF;
			cnt_reg <= 16'h0000;
			ramp_reg <= 16'h0000;
			tick_reg <= 16'h0000;
			prop_reg <= 1'b0;
			prop_hist_reg <= 2'b00;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			ramp_reg <= ramp_next;
			tick_reg <= tick_next;
			prop_reg <= prop_next;
			prop_hist_reg <= prop_hist_next;
		end
	end
	assign shared_fault_line.o  = 1'b0;
	assign shared_fault_line.oe = prop_reg;

	// Status, alert and fault log strobes
	logic [4:0]  st_reg, st_next;
	logic [15:0] log_cnt_reg, log_cnt_next;
	logic        alert_reg, alert_next, lw_reg, lw_next, lm_reg, lm_next, store_cmd, clr_cmd;
	logic        held_off;
	assign store_cmd = wr && paddr == ADDR_CMD && pwdata[CMD_STORE];
	assign clr_cmd   = wr && paddr == ADDR_CMD && pwdata[CMD_CLEAR];
	assign held_off  = respond_low && (state_reg != ST_FAULTED) && (state_reg != ST_OFF || cfg.on);
	always_comb begin
		st_next = st_reg;
		if (wr && paddr == ADDR_STATUS)
			st_next = st_reg & ~pwdata[4:0];
		if (log_evt || store_cmd)
			st_next[ST_LOG_PRESENT] = 1'b1;
		if (held_off && !cfg.manager)
			st_next[ST_IO_LOW] = 1'b1;
		if (held_off && cfg.manager)
			st_next[ST_SHARED_IN] = 1'b1;
		st_next[ST_INPUT_OFF] = vin_low;
		st_next[ST_TB_LOW] = tb_stalled_reg;
		log_cnt_next = (log_evt || store_cmd) ? log_cnt_reg + 16'h0001 : log_cnt_reg;
		alert_next = alert_reg;
		if (log_evt && !log_is_resp)
			alert_next = 1'b0;
		else if (clr_cmd)
			alert_next = 1'b1;
		lw_next = log_evt | store_cmd;
		lm_next = store_cmd & ~log_evt;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= 5'h00;
			log_cnt_reg <= 16'h0000;
			alert_reg <= 1'b1;
			lw_reg <= 1'b0;
			lm_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			log_cnt_reg <= log_cnt_next;
			alert_reg <= alert_next;
			lw_reg <= lw_next;
			lm_reg <= lm_next;
		end
	end
	assign alert_out_n = alert_reg;
	assign log_write   = lw_reg;
	assign log_manual  = lm_reg;

	// Outputs to the power stage
	logic out_on;
	assign out_on = (state_reg == ST_ON) || (state_reg == ST_RAMP) || (state_reg == ST_TOFF);
	logic oen_reg, oen_next, pen_reg, pen_next;
	// Only one enable follows the channel, chosen by the manager setting
	always_comb begin
		oen_next = cfg.manager & out_on;
		pen_next = ~cfg.manager & out_on;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oen_reg <= 1'b0;
			pen_reg <= 1'b0;
		end else begin
			oen_reg <= oen_next;
			pen_reg <= pen_next;
		end
	end
	assign supply_output_enable = oen_reg;
	assign power_enable         = pen_reg;
	assign ramp_level           = ramp_reg;

	// APB read path: zero wait states, error on unmapped addresses
	logic [31:0] rdata_next;
	logic        mapped;
	always_comb begin
		mapped = 1'b1;
		rdata_next = 32'h0000_0000;
		case (paddr)
			ADDR_CTRL:       rdata_next = ctrl_reg;
			ADDR_ON_DELAY:   rdata_next = {16'h0000, ton_reg};
			ADDR_ON_RISE:    rdata_next = {16'h0000, rise_reg};
			ADDR_OFF_DELAY:  rdata_next = {16'h0000, toff_reg};
			ADDR_RETRY:      rdata_next = {16'h0000, retry_reg};
			ADDR_STATUS:     rdata_next = {22'h00_0000, state_reg, prop_reg, 1'b0, st_reg};
			ADDR_CMD:        rdata_next = 32'h0000_0000;
			ADDR_LOG_COUNT:  rdata_next = {16'h0000, log_cnt_reg};
			ADDR_ID:         rdata_next = DEVICE_ID;
			default:         mapped = 1'b0;
		endcase
	end
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	// Read data is caught at the setup edge so it leaves a flop; it shows state one cycle early
	logic [31:0] prdata_reg, prdata_next;
	always_comb begin
		prdata_next = 32'h0000_0000;
		if (psel && !penable && !pwrite)
			prdata_next = rdata_next;
		else if (rd)
			prdata_next = prdata_reg;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_reg <= 32'h0000_0000;
		else
			prdata_reg <= prdata_next;
	end
	assign prdata  = prdata_reg;
endmodule

/* fault_seq_props.sv */
// Assertion checker for the shared-fault coordinator, watching top ports only.
// Assumes one pclk domain with async active-low presetn; bound from the bench.
`timescale 1ns/1ps
module fault_seq_props (
	input wire logic                     pclk,
	input wire logic                     presetn,
	input wire logic                     input_below_off,
	input wire logic                     input_above_on,
	input wire logic                     shared_timebase_line_i,
	input wire fault_seq_pkg::od_drive_t shared_fault_line,
	input wire fault_seq_pkg::od_drive_t shared_timebase_line,
	input wire logic                     alert_out_n,
	input wire logic                     supply_output_enable,
	input wire logic                     power_enable,
	input wire logic                     log_write,
	input wire logic                     log_manual
);
	import fault_seq_pkg::*;
	logic [6:0] quiet_reg;
	logic [6:0] quiet_next;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Cycles the timebase line has sat low; saturates so a long stall never wraps
	always_comb begin
		quiet_next = quiet_reg;
		if (shared_timebase_line_i)
			quiet_next = 7'h00;
		else if (quiet_reg != 7'h7f)
			quiet_next = quiet_reg + 7'h01;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			quiet_reg <= 7'h00;
		else
			quiet_reg <= quiet_next;
	end
	// Steps of input loss, input return and a held fault pull
	sequence s_vin_lost; input_below_off [*5]; endsequence
	sequence s_vin_good; (input_above_on && !input_below_off) [*8]; endsequence
	sequence s_pulling; shared_fault_line.oe [*2]; endsequence
	property p_od_low; !shared_fault_line.o && !shared_timebase_line.o; endproperty
	property p_fault_log; $rose(shared_fault_line.oe) |-> log_write; endproperty
	property p_fault_alert; $rose(shared_fault_line.oe) |-> ##[0:1] !alert_out_n; endproperty
	property p_pull_off; s_pulling |-> !power_enable && !supply_output_enable; endproperty
	property p_log_pulse; log_write |=> !log_write; endproperty
	property p_manual; log_manual |-> log_write; endproperty
	property p_vin_hold; s_vin_lost |-> shared_timebase_line.oe; endproperty
	property p_tb_toggle; s_vin_good |-> ##[0:8] !shared_timebase_line.oe; endproperty
	property p_stall_off; quiet_reg >= 7'h2c |-> !power_enable && !supply_output_enable; endproperty
	property p_one_en; !(power_enable && supply_output_enable); endproperty
	a_od_low: assert property (p_od_low) else $error("open-drain pin driven high");
	a_fault_log: assert property (p_fault_log) else $error("no log after own fault");
	a_fault_alert: assert property (p_fault_alert) else $error("alert not low at fault");
	a_pull_off: assert property (p_pull_off) else $error("output on while pulling fault line");
	a_log_pulse: assert property (p_log_pulse) else $error("log strobe longer than one cycle");
	a_manual: assert property (p_manual) else $error("snapshot without log strobe");
	a_vin_hold: assert property (p_vin_hold) else $error("timebase not held on input loss");
	a_tb_toggle: assert property (p_tb_toggle) else $error("timebase not released");
	a_stall_off: assert property (p_stall_off) else $error("output on with stalled timebase");
	a_one_en: assert property (p_one_en) else $error("both enables high");
endmodule

/* peer_device.sv */
// Behavioural peer device sharing the fault and timebase lines.
// Assumes the bench forms each wired-AND with a pull-up and feeds it back.
`timescale 1ns/1ps
module peer_device (
	input  wire logic vin_lost,
	input  wire logic raise_fault,
	output logic      fault_pull,
	output logic      timebase_pull
);
	logic beat_reg;
	// Short low beat each 320 ns, phase unrelated to pclk; never starves the line
	initial begin
		beat_reg = 1'b0;
		#13;
		forever begin
			#280 beat_reg = 1'b1;
			#40 beat_reg = 1'b0;
		end
	end
	// Pulls only; input loss holds the timebase low until it returns
	assign timebase_pull = vin_lost | beat_reg;
	assign fault_pull    = raise_fault;
endmodule

/* tb.sv */
// Self-checking bench: coordinator plus one peer on both open-drain lines.
// Assumes pull-ups on both lines; reads are checked from a queue of notes.
`timescale 1ns/1ps
module tb;
	import fault_seq_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, mgr;
	logic        fault_detect, input_below_off, input_above_on, alert_out_n;
	logic        supply_output_enable, power_enable, log_write, log_manual;
	logic        fault_line_i, tb_line_i, vin_lost, raise_fault, peer_fault, peer_tb;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] ramp_level, ton;
	od_drive_t   fault_od, tb_od;
	logic [64:0] exp_q[$];
	logic [64:0] x;
	int          err_count, samples_checked, cyc, man_cnt, n, seed;
	logic [7:0]  ra[6] = '{ADDR_CTRL, ADDR_ON_DELAY, ADDR_ON_RISE, ADDR_OFF_DELAY, ADDR_RETRY, ADDR_ID};
	logic [31:0] rv[6] = '{CTRL_RESET, 32'(ON_DELAY_RESET), 32'(ON_RISE_RESET), 32'(TOFF_RESET),
		32'(RETRY_RESET), DEVICE_ID};

	// Wired-AND with pull-ups
	assign fault_line_i = !(fault_od.oe && !fault_od.o) && !peer_fault;
	assign tb_line_i    = !(tb_od.oe && !tb_od.o) && !peer_tb;

	shared_fault_sequence_coord shared_fault_sequence_coord_inst (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.fault_detect, .input_below_off, .input_above_on,
		.shared_fault_line_i(fault_line_i), .shared_fault_line(fault_od),
		.shared_timebase_line_i(tb_line_i), .shared_timebase_line(tb_od),
		.alert_out_n, .supply_output_enable, .power_enable, .ramp_level, .log_write, .log_manual);
	peer_device peer_device_inst (.vin_lost, .raise_fault, .fault_pull(peer_fault), .timebase_pull(peer_tb));

	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic win(string nm, int lo, int hi);
		chk(nm, 32'h0000_0001, 32'(n >= lo && n <= hi));
	endtask
	// One APB transfer, entered right after a rising edge
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m, logic er);
		exp_q.push_back({er, m, e & m});
		apb(1'b0, a, 32'h0000_0000);
	endtask
	// Bounded wait: 0 delivery enable, 1 fault pull, 2 ramp at full scale
	task automatic wait_on(int s, logic lvl);
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while ((s == 1 ? fault_od.oe : s == 2 ? ramp_level === 16'hffff :
			mgr ? supply_output_enable : power_enable) !== lvl && n < 4000);
		@(posedge pclk);
	endtask
	task automatic final_report;
		if (err_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// Read monitor, snapshot counter and run limit
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) begin
			x = exp_q.pop_front();
			chk("prdata", x[31:0], prdata & x[63:32]);
			chk("pslverr", {31'h0000_0000, x[64]}, {31'h0000_0000, pslverr});
		end
		if (log_manual === 1'b1)
			man_cnt++;
		cyc++;
		if (cyc == 40000) begin
			err_count++;
			final_report();
		end
	end
	initial begin
		{presetn, psel, penable, pwrite, fault_detect, input_above_on, vin_lost, raise_fault, mgr} = '0;
		input_below_off = 1'b1;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		seed = 32'h5f0a_4699;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		repeat (20) @(posedge pclk);
		for (int i = 0; i < 6; i++)
			rd(ra[i], rv[i], 32'hffff_ffff, 1'b0);
		rd(ADDR_STATUS, 32'h0000_0008, 32'h0000_0008, 1'b0);
		rd(8'h24, 32'h0000_0000, 32'h0000_0000, 1'b1);
		@(negedge pclk);
		chk("timebase_hold", 32'h0000_0001, 32'(tb_od.oe));
		@(posedge pclk);
		// Power up with a random on delay; input return restarts the timebase
		ton = 16'(($random(seed) & 3) + 1);
		apb(1'b1, ADDR_ON_DELAY, {16'h0000, ton});
		apb(1'b1, ADDR_ON_RISE, 32'h0000_0001);
		apb(1'b1, ADDR_OFF_DELAY, 32'h0000_0002);
		apb(1'b1, ADDR_RETRY, 32'h0000_0002);
		apb(1'b1, ADDR_CTRL, 32'h0000_008f);
		input_below_off <= 1'b0;
		input_above_on <= 1'b1;
		wait_on(0, 1'b1);
		win("power_up", ton * TICK_CYCLES, (ton + 1) * TICK_CYCLES + 80);
		wait_on(2, 1'b1);
		win("ramp", 0, 2 * TICK_CYCLES);
		rd(ADDR_STATUS, 32'h0000_0000, 32'h0000_0018, 1'b0);
		// Own fault: pull, log, alert, then retry and re-sequence
		fault_detect <= 1'b1;
		repeat (3) @(negedge pclk);
		chk("fault_pull", 32'h0000_0001, 32'(fault_od.oe));
		chk("power_off", 32'h0000_0000, 32'(power_enable));
		chk("alert", 32'h0000_0000, 32'(alert_out_n));
		@(posedge pclk);
		rd(ADDR_STATUS, 32'h0000_0041, 32'h0000_0041, 1'b0);
		rd(ADDR_LOG_COUNT, 32'h0000_0001, 32'hffff_ffff, 1'b0);
		fault_detect <= 1'b0;
		wait_on(1, 1'b0);
		win("retry", TICK_CYCLES - 20, 2 * TICK_CYCLES + 20);
		wait_on(0, 1'b1);
		win("reseq", ton * TICK_CYCLES, (ton + 1) * TICK_CYCLES + 20);
		// Manager responder driven by the peer
		mgr = 1'b1;
		apb(1'b1, ADDR_CTRL, 32'h0000_00a5);
		wait_on(0, 1'b1);
		raise_fault <= 1'b1;
		wait_on(0, 1'b0);
		win("respond", 0, 6);
		rd(ADDR_STATUS, 32'h0000_0005, 32'h0000_0007, 1'b0);
		rd(ADDR_LOG_COUNT, 32'h0000_0002, 32'hffff_ffff, 1'b0);
		raise_fault <= 1'b0;
		wait_on(0, 1'b1);
		win("mgr_reseq", ton * TICK_CYCLES, (ton + 1) * TICK_CYCLES + 20);
		// Turn-off delay honoured before the enable drops
		apb(1'b1, ADDR_CTRL, 32'h0000_00e5);
		raise_fault <= 1'b1;
		wait_on(0, 1'b0);
		win("toff", TICK_CYCLES, 2 * TICK_CYCLES + 20);
		raise_fault <= 1'b0;
		wait_on(0, 1'b1);
		apb(1'b1, ADDR_CMD, 32'h0000_0001);
		rd(ADDR_LOG_COUNT, 32'h0000_0004, 32'hffff_ffff, 1'b0);
		chk("manual", 32'h0000_0001, 32'(man_cnt));
		// Peer loses input: timebase stalls, then restarts as time zero
		apb(1'b1, ADDR_CTRL, 32'h0000_00a5);
		vin_lost <= 1'b1;
		wait_on(0, 1'b0);
		win("stall_off", 0, 60);
		vin_lost <= 1'b0;
		wait_on(0, 1'b1);
		win("restart", ton * TICK_CYCLES, (ton + 1) * TICK_CYCLES + 60);
		// Ignore setting starts the channel with the fault line low
		raise_fault <= 1'b1;
		wait_on(0, 1'b0);
		apb(1'b1, ADDR_CTRL, 32'h0000_00b5);
		wait_on(0, 1'b1);
		win("ignore", ton * TICK_CYCLES - 10, (ton + 1) * TICK_CYCLES + 20);
		final_report();
	end
endmodule

bind shared_fault_sequence_coord fault_seq_props fault_seq_props_inst (
	.pclk, .presetn, .input_below_off, .input_above_on, .shared_timebase_line_i, .shared_fault_line,
	.shared_timebase_line, .alert_out_n, .supply_output_enable, .power_enable, .log_write, .log_manual);
